// >>> core/pfm_pin_mux.sv
// pin function multiplexer for port one (8 pins) and port three (4 pins)
// assumes fuse and mode bits come from logic on clk, pins from outside
`timescale 1ns/1ns
`default_nettype none
`include "pfm_cfg.svh"

module pfm_pin_mux
    import pfm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    // configuration from fuses and mode registers
    input  wire logic       reset_fuse_en,
    input  wire logic       rc_osc_sel,
    input  wire logic       ocd_en,
    input  wire logic       divided_clock_output_en,
    input  wire logic       spi_en,
    input  wire logic       spi_master,
    input  wire logic       uart_en,
    input  wire logic       double_speed_req,
    // port latches and drive enables from the port logic
    input  wire logic [7:0] port1_latch,
    input  wire logic [7:0] port1_drive,
    input  wire logic [3:0] port3_latch,
    input  wire logic [3:0] port3_drive,
    // alternate function outputs from peripherals
    input  wire logic       spi_mosi_out,
    input  wire logic       spi_sck_out,
    input  wire logic       spi_miso_out,
    input  wire logic       uart_txd,
    input  wire logic       dbg_data_out,
    input  wire logic       dbg_data_oe,
    // pin pads
    input  wire logic [7:0] port1_pin_in,
    output var  logic [7:0] port1_pin_out,
    output var  logic [7:0] port1_pin_oe_n,
    input  wire logic [3:0] port3_pin_in,
    output var  logic [3:0] port3_pin_out,
    output var  logic [3:0] port3_pin_oe_n,
    // filtered pin values and the fixed clock ratio toward the core
    output var  logic [7:0] port1_in,
    output var  logic [3:0] port3_in,
    output var  logic [7:0] pin_event_in,
    output var  logic       ext_reset_n,
    output var  logic       debug_serial_clock_in,
    output var  logic       debug_serial_data_in,
    output var  logic       spi_mosi_in,
    output var  logic       spi_sck_in,
    output var  logic       spi_miso_in,
    output var  logic       spi_ss_n,
    output var  logic       uart_rxd,
    output var  logic [1:0] cpu_clk_ratio
);

    // ****************************************************************
    // pin selection function
    // ****************************************************************
    // returns {oe_n, out}; an owning alternate function wins over the
    // port latch, and an input-only function keeps the pad released
    function automatic logic [1:0] pin_pick(
        input logic drive_en,
        input logic latch,
        input logic alt_on,
        input logic alt_drive,
        input logic alt_val
    );
        if (alt_on) begin
            pin_pick = {~alt_drive, alt_val};
        end else begin
            pin_pick = {~drive_en, latch};
        end
    endfunction

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [11:0] sync1;     // first stage, read only by sync2
    logic [11:0] sync2;     // second stage
    logic [11:0] sync3;     // third stage
    logic [11:0] filt;      // accepted pin level
    wire  [11:0] pin_raw;   // both ports, port three on top
    wire  [11:0] next_filt; // level once stages two and three agree

    assign pin_raw = {port3_pin_in, port1_pin_in};

    // a one-cycle glitch never shows in both late stages at once,
    // so it is dropped at the cost of one extra cycle of latency
    genvar g;
    generate
        for (g = 0; g < `PFM_PIN_W; g++) begin : g_filt
            assign next_filt[g] = (sync2[g] == sync3[g]) ? sync2[g]
                                                         : filt[g];
        end
    endgenerate

    // shift chain; idle level is high like a pulled-up pad
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= 12'hfff;
            sync2 <= 12'hfff;
            sync3 <= 12'hfff;
            filt  <= 12'hfff;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    // ****************************************************************
    // role decode
    // ****************************************************************
    wire spi_slave_on;          // spi active in slave role
    wire clkdiv_en;             // divided clock may run
    wire clk_half;              // divided clock from the divider
    wire p13_alt;               // pin 1.3 taken by reset or debug
    pfm_p32_role_type p32_role; // owner of pin 3.2
    pfm_p33_role_type p33_role; // owner of pin 3.3

    assign spi_slave_on = spi_en & ~spi_master;
    assign p13_alt      = reset_fuse_en | ocd_en;

    // without the rc oscillator pin 3.2 belongs to it, and pin 3.3 too unless debug is on
    assign p32_role = !rc_osc_sel ? P32_OSC
                    : ocd_en      ? P32_DEBUG
                    :               P32_PORT;
    // an external clock needs only the input pad, so debug data
    // moves to the output pad
    assign p33_role = (!rc_osc_sel && ocd_en) ? P33_DEBUG
                    : !rc_osc_sel             ? P33_OSC
                    : divided_clock_output_en               ? P33_DIVIDED_CLOCK_OUTPUT
                    :                           P33_PORT;

    assign clkdiv_en = (p33_role == P33_DIVIDED_CLOCK_OUTPUT);

    // divided clock source for pin 3.3
    pfm_clkdiv u_clkdiv (
        .clk      (clk),
        .rst      (rst),
        .en       (clkdiv_en),
        .clk_half (clk_half)
    );

    // ****************************************************************
    // port one pad selection
    // ****************************************************************
    wire [1:0] p1_sel [8]; // {oe_n, out} per port one pin

    // bits zero to two are plain port pins
    generate
        for (g = 0; g < 3; g++) begin : g_p1_plain
            assign p1_sel[g] = pin_pick(port1_drive[g], port1_latch[g],
                                        1'h0, 1'h0, 1'h0);
        end
    endgenerate

    // reset or debug clock: input only, otherwise port
    assign p1_sel[3] = pin_pick(port1_drive[3], port1_latch[3],
                                p13_alt, 1'h0, 1'h0);
    // slave select is input only while spi is slave
    assign p1_sel[4] = pin_pick(port1_drive[4], port1_latch[4],
                                spi_slave_on, 1'h0, 1'h0);
    // mosi and sck drive in master role only
    assign p1_sel[5] = pin_pick(port1_drive[5], port1_latch[5],
                                spi_en, spi_master,
                                spi_mosi_out);
    assign p1_sel[6] = pin_pick(port1_drive[6], port1_latch[6],
                                spi_en, ~spi_master,
                                spi_miso_out);
    assign p1_sel[7] = pin_pick(port1_drive[7], port1_latch[7],
                                spi_en, spi_master,
                                spi_sck_out);

    // ****************************************************************
    // port three pad selection
    // ****************************************************************
    wire [1:0] p3_sel [4]; // {oe_n, out} per port three pin
    logic      p32_alt;    // pin 3.2 owned by a function
    logic      p32_drv;    // pin 3.2 function drives
    logic      p32_val;    // pin 3.2 function value
    logic      p33_alt;    // pin 3.3 owned by a function
    logic      p33_drv;    // pin 3.3 function drives
    logic      p33_val;    // pin 3.3 function value

    assign p3_sel[0] = pin_pick(port3_drive[0], port3_latch[0],
                                uart_en, 1'h0, 1'h0);
    assign p3_sel[1] = pin_pick(port3_drive[1], port3_latch[1],
                                uart_en, 1'h1, uart_txd);

    // oscillator ownership keeps the pad released for the amplifier
    always_comb begin
        p32_alt = 1'h0;
        p32_drv = 1'h0;
        p32_val = 1'h0;
        unique case (p32_role)
            P32_PORT: begin
                p32_alt = 1'h0;
            end
            P32_OSC: begin
                p32_alt = 1'h1;
            end
            P32_DEBUG: begin
                p32_alt = 1'h1;
                p32_drv = dbg_data_oe;
                p32_val = dbg_data_out;
            end
            default: begin
                p32_alt = 1'h1; // unused code: keep the pad released
            end
        endcase
    end

    // pin 3.3 owner drives according to its role
    always_comb begin
        p33_alt = 1'h0;
        p33_drv = 1'h0;
        p33_val = 1'h0;
        unique case (p33_role)
            P33_PORT: begin
                p33_alt = 1'h0;
            end
            P33_OSC: begin
                p33_alt = 1'h1;
            end
            P33_DIVIDED_CLOCK_OUTPUT: begin
                p33_alt = 1'h1;
                p33_drv = 1'h1;
                p33_val = clk_half;
            end
            P33_DEBUG: begin
                p33_alt = 1'h1;
                p33_drv = dbg_data_oe;
                p33_val = dbg_data_out;
            end
        endcase
    end

    assign p3_sel[2] = pin_pick(port3_drive[2], port3_latch[2],
                                p32_alt, p32_drv, p32_val);
    assign p3_sel[3] = pin_pick(port3_drive[3], port3_latch[3],
                                p33_alt, p33_drv, p33_val);

    // ****************************************************************
    // toward-core selection
    // ****************************************************************
    wire next_ext_reset_n; // reset pin level when the fuse is on
    wire next_dbg_clk;     // debug clock while debug is on
    wire next_dbg_data;    // debug data from the owning pad
    wire next_ss_n;        // slave select, idle high
    wire next_rxd;         // receive data, idle high

    assign next_ext_reset_n = reset_fuse_en ? filt[3] : 1'h1;
    assign next_dbg_clk     = ocd_en ? filt[3] : 1'h0;
    assign next_dbg_data    = !ocd_en    ? 1'h1
                            : rc_osc_sel ? filt[10]
                            :              filt[11];
    assign next_ss_n        = spi_en ? filt[4] : 1'h1;
    assign next_rxd         = uart_en ? filt[8] : 1'h1;

    // ****************************************************************
    // output registers
    // ****************************************************************
    // pads are registered so no decode glitch ever reaches a pin;
    // the pads come out of reset released
    always_ff @(posedge clk) begin
        if (rst) begin
            port1_pin_out  <= 8'hff;
            port1_pin_oe_n <= 8'hff;
            port3_pin_out  <= 4'hf;
            port3_pin_oe_n <= 4'hf;
        end else begin
            for (int i = 0; i < `PFM_P1_W; i++) begin
                port1_pin_oe_n[i] <= p1_sel[i][1];
                port1_pin_out[i]  <= p1_sel[i][0];
            end
            for (int i = 0; i < `PFM_P3_W; i++) begin
                port3_pin_oe_n[i] <= p3_sel[i][1];
                port3_pin_out[i]  <= p3_sel[i][0];
            end
        end
    end

    // filtered values and the fixed clock ratio toward the core;
    // the ratio ignores any double speed request by construction
    always_ff @(posedge clk) begin
        if (rst) begin
            port1_in              <= 8'hff;
            port3_in              <= 4'hf;
            pin_event_in          <= 8'hff;
            ext_reset_n           <= 1'h1;
            debug_serial_clock_in <= 1'h0;
            debug_serial_data_in  <= 1'h1;
            spi_mosi_in           <= 1'h1;
            spi_sck_in            <= 1'h1;
            spi_miso_in           <= 1'h1;
            spi_ss_n              <= 1'h1;
            uart_rxd              <= 1'h1;
            cpu_clk_ratio         <= `PFM_CPU_CLK_DIV;
        end else begin
            port1_in              <= filt[7:0];
            port3_in              <= filt[11:8];
            pin_event_in          <= filt[7:0];
            ext_reset_n           <= next_ext_reset_n;
            debug_serial_clock_in <= next_dbg_clk;
            debug_serial_data_in  <= next_dbg_data;
            spi_mosi_in           <= filt[5];
            spi_sck_in            <= filt[7];
            spi_miso_in           <= filt[6];
            spi_ss_n              <= next_ss_n;
            uart_rxd              <= next_rxd;
            cpu_clk_ratio         <= `PFM_CPU_CLK_DIV;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_port_bit3;
        !reset_fuse_en && !ocd_en && port1_drive[3] |=>
            !port1_pin_oe_n[3] && port1_pin_out[3] == $past(port1_latch[3]);
    endproperty
    a_port_bit3: assert property (p_port_bit3)
        else $error("pin 1.3 not driven as port");

    property p_reset_pin;
        reset_fuse_en && !filt[3] |=> !ext_reset_n && port1_pin_oe_n[3];
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("low reset pin not passed on");

    property p_osc_release;
        rc_osc_sel && !ocd_en && !divided_clock_output_en && port3_drive[3] |=>
            !port3_pin_oe_n[3] && port3_pin_out[3] == $past(port3_latch[3]);
    endproperty
    a_osc_release: assert property (p_osc_release)
        else $error("oscillator pin not released to port");

    property p_divided_clock_output;
        (rc_osc_sel && divided_clock_output_en && !ocd_en)[*3] |=>
            !port3_pin_oe_n[3] && $changed(port3_pin_out[3]);
    endproperty
    a_divided_clock_output: assert property (p_divided_clock_output)
        else $error("divided clock not toggling on pin 3.3");

    property p_dbg_rc;
        ocd_en && rc_osc_sel |=> port3_pin_out[2] == $past(dbg_data_out)
            && port3_pin_oe_n[2] == !$past(dbg_data_oe);
    endproperty
    a_dbg_rc: assert property (p_dbg_rc)
        else $error("debug data not on pin 3.2");

    property p_dbg_ext;
        ocd_en && !rc_osc_sel |=> port3_pin_out[3] == $past(dbg_data_out)
            && port3_pin_oe_n[3] == !$past(dbg_data_oe)
            && port3_pin_oe_n[2];
    endproperty
    a_dbg_ext: assert property (p_dbg_ext)
        else $error("debug data not on pin 3.3");

    property p_dbg_clk;
        ocd_en ##1 ocd_en |-> debug_serial_clock_in == $past(filt[3])
            && port1_pin_oe_n[3];
    endproperty
    a_dbg_clk: assert property (p_dbg_clk)
        else $error("debug clock not taken from pin 1.3");

    property p_spi_master;
        spi_en && spi_master |=> !port1_pin_oe_n[5] && !port1_pin_oe_n[7]
            && port1_pin_oe_n[6] && port1_pin_out[7] == $past(spi_sck_out);
    endproperty
    a_spi_master: assert property (p_spi_master)
        else $error("spi master pad directions wrong");

    property p_spi_slave;
        spi_slave_on |=> port1_pin_oe_n[5] && port1_pin_oe_n[7]
            && !port1_pin_oe_n[6] && port1_pin_out[6] == $past(spi_miso_out);
    endproperty
    a_spi_slave: assert property (p_spi_slave)
        else $error("spi slave pad directions wrong");

    property p_slave_sel;
        spi_slave_on |=> port1_pin_oe_n[4] && spi_ss_n == $past(filt[4]);
    endproperty
    a_slave_sel: assert property (p_slave_sel)
        else $error("slave select not an input");

    property p_event_in;
        $stable(port1_pin_in)[*6] |-> pin_event_in == port1_pin_in;
    endproperty
    a_event_in: assert property (p_event_in)
        else $error("steady pin not seen as event input");

    property p_uart;
        uart_en |=> port3_pin_oe_n[0] && !port3_pin_oe_n[1]
            && port3_pin_out[1] == $past(uart_txd);
    endproperty
    a_uart: assert property (p_uart)
        else $error("uart pads wrong");

    property p_clk_ratio;
        double_speed_req |=> cpu_clk_ratio == `PFM_CPU_CLK_DIV
            && $stable(cpu_clk_ratio);
    endproperty
    a_clk_ratio: assert property (p_clk_ratio)
        else $error("cpu clock ratio changed");

    c_divided_clock_output: cover property (clkdiv_en [*4]);
    c_dbg_ext: cover property (ocd_en && !rc_osc_sel && dbg_data_oe);
    c_spi_slave: cover property (spi_slave_on ##1 spi_slave_on);
    c_reset_low: cover property (reset_fuse_en && !ext_reset_n);

endmodule
`default_nettype wire

// >>> core/pfm_cfg.svh
// constants for the pin function multiplexer: pin indices, reset values
// and clock ratios; assumes one 250 MHz core clock and no register bus
// Notes on behaviour
// - reset fuse and debug off: pin 1.3 is plain port
// - reset fuse on: pin 1.3 is low reset
// - rc oscillator frees oscillator pins as port
// - rc oscillator: pin 3.3 may output clock/2
// - debug plus rc oscillator: data on 3.2
// - debug plus external clock: data on 3.3
// - debug serial clock enters on pin 1.3
// - spi master drives mosi, sck; slave inputs
// - spi master reads miso; slave drives it
// - spi slave select enters on pin 1.4
// - every port one bit is event input
// - uart receive data enters on pin 3.0
// - uart transmit data leaves on pin 3.1
// - cpu clock equals oscillator, no divider
// - double speed mode absent, requests ignored
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// ****************************************************************
// widths and pin positions
// ****************************************************************
`define PFM_P1_W        8
`define PFM_P3_W        4
`define PFM_PIN_W       12
`define PFM_P1_RST_BIT  3
`define PFM_P1_SS_BIT   4
`define PFM_P1_MOSI_BIT 5
`define PFM_P1_MISO_BIT 6
`define PFM_P1_SCK_BIT  7
`define PFM_P3_RXD_BIT  0
`define PFM_P3_TXD_BIT  1
`define PFM_P3_OSCI_BIT 2
`define PFM_P3_OSCO_BIT 3

// ****************************************************************
// reset values and clock figures
// ****************************************************************
`define PFM_PIN_RST     1'h1
`define PFM_OE_N_RST    1'h1
`define PFM_CLK_PERIOD_NS 4
`define PFM_CPU_CLK_DIV 2'h1
`define PFM_DIVIDED_CLOCK_OUTPUT_DIV  2'h2

`endif

// >>> core/pfm_pkg.sv
// types shared by the pin function multiplexer modules
// assumes nothing beyond a SystemVerilog compiler
package pfm_pkg;

    // what drives or owns port three bit two
    typedef enum logic [1:0] {
        P32_PORT,
        P32_OSC,
        P32_DEBUG
    } pfm_p32_role_type;

    // what drives or owns port three bit three
    typedef enum logic [1:0] {
        P33_PORT,
        P33_OSC,
        P33_DIVIDED_CLOCK_OUTPUT,
        P33_DEBUG
    } pfm_p33_role_type;

endpackage

// >>> core/pfm_clkdiv.sv
// divide-by-two clock generator for the divided clock output pin
// assumes the core clock clk and a synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
`include "pfm_cfg.svh"

module pfm_clkdiv (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic en,
    output var  logic clk_half
);

    // ****************************************************************
    // toggle register
    // ****************************************************************
    // one toggle per core edge gives the divide by PFM_DIVIDED_CLOCK_OUTPUT_DIV;
    // held low while disabled so the pin starts from a known phase
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_half <= 1'h0;
        end else if (en) begin
            clk_half <= ~clk_half;
        end else begin
            clk_half <= 1'h0;
        end
    end

endmodule
`default_nettype wire

// >>> sim/pfm_board.sv
// board model for the pin function multiplexer pads
// assumes low-active pad enables and a pull-up on every pad
`timescale 1ns/1ns
`default_nettype none

module pfm_board (
    input  wire logic [11:0] pin_out,
    input  wire logic [11:0] pin_oe_n,
    input  wire logic [11:0] ext_val,
    input  wire logic [11:0] ext_drive,
    output var  logic [11:0] pin_in
);
    // device drive wins, then an outside part, else the pull-up;
    // outside parts only drive released pads, so no contention
    always_comb begin
        pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drive & ext_val)
               | (pin_oe_n & ~ext_drive);
    end
endmodule
`default_nettype wire

// >>> sim/pin_function_mux_tb_top.sv
// self-checking bench for the pin function multiplexer
// assumes the board model in pfm_board.sv and a 250 MHz clock
`timescale 1ns/1ns
`default_nettype none

module pin_function_mux_tb_top;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cfg = 8'h00;   // fuse rc ocd divided_clock_output spi master uart dsr
    logic [7:0]  p1l = 8'h00, p1d = 8'h00;
    logic [3:0]  p3l = 4'h0, p3d = 4'h0;
    logic [5:0]  alt = 6'h00;   // mosi sck miso txd ddo ddoe
    logic [11:0] ext_val = 12'h000, ext_drive = 12'h000, pad;
    logic [7:0]  p1o, p1oe, p1i, ev;
    logic [3:0]  p3o, p3oe, p3i;
    wire  [9:0]  misc;          // one bit per single-bit core-side output, two for the clock ratio
    integer      seed = 32'hf0f0, n_mismatch = 0, checks = 0, cycles = 0;

    always #2 clk = ~clk;

    pfm_pin_mux pfm_pin_mux_inst (
        .clk(clk), .rst(rst), .reset_fuse_en(cfg[0]), .rc_osc_sel(cfg[1]),
        .ocd_en(cfg[2]), .divided_clock_output_en(cfg[3]), .spi_en(cfg[4]),
        .spi_master(cfg[5]), .uart_en(cfg[6]), .double_speed_req(cfg[7]),
        .port1_latch(p1l), .port1_drive(p1d), .port3_latch(p3l),
        .port3_drive(p3d), .spi_mosi_out(alt[5]), .spi_sck_out(alt[4]),
        .spi_miso_out(alt[3]), .uart_txd(alt[2]), .dbg_data_out(alt[1]),
        .dbg_data_oe(alt[0]), .port1_pin_in(pad[7:0]), .port1_pin_out(p1o),
        .port1_pin_oe_n(p1oe), .port3_pin_in(pad[11:8]),
        .port3_pin_out(p3o), .port3_pin_oe_n(p3oe), .port1_in(p1i),
        .port3_in(p3i), .pin_event_in(ev), .ext_reset_n(misc[9]),
        .debug_serial_clock_in(misc[8]), .debug_serial_data_in(misc[7]),
        .spi_ss_n(misc[6]), .uart_rxd(misc[5]), .spi_mosi_in(misc[4]),
        .spi_sck_in(misc[3]), .spi_miso_in(misc[2]),
        .cpu_clk_ratio(misc[1:0]));

    pfm_board pfm_board_inst (
        .pin_out({p3o, p1o}), .pin_oe_n({p3oe, p1oe}), .ext_val(ext_val),
        .ext_drive(ext_drive), .pin_in(pad));

    // ****************************************************************
    // expectation and reporting
    // ****************************************************************
    // expected {value, enable_n} of all twelve pads from the config
    function automatic logic [23:0] exp_pad();
        logic [11:0] o, e;
        o = {p3l, p1l};
        e = ~{p3d, p1d};
        if (cfg[0] | cfg[2]) e[3] = 1'b1;
        if (cfg[4]) begin
            if (!cfg[5]) e[4] = 1'b1;
            e[5] = ~cfg[5]; o[5] = alt[5];
            e[7] = ~cfg[5]; o[7] = alt[4];
            e[6] = cfg[5]; o[6] = alt[3];
        end
        if (cfg[6]) begin
            e[8] = 1'b1;
            e[9] = 1'b0; o[9] = alt[2];
        end
        if (!cfg[1]) e[11:10] = 2'h3;
        if (cfg[2] & cfg[1]) begin
            e[10] = ~alt[0]; o[10] = alt[1];
        end
        if (cfg[2] & !cfg[1]) begin
            e[11] = ~alt[0]; o[11] = alt[1];
        end
        return {o, e};
    endfunction

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************************************
    // one configuration: drive, settle past the 5-edge filter, compare
    // ****************************************************************
    task automatic step(input logic [7:0] c, input bit fix);
        logic [31:0] r;
        logic [23:0] x;
        logic [11:0] m, pv, lo, ai, mi;
        @(posedge clk);
        r = $random(seed);
        cfg <= fix ? c : r[7:0];
        p1l <= r[15:8]; p1d <= r[23:16]; p3l <= r[27:24]; p3d <= r[31:28];
        r = $random(seed);
        alt <= r[5:0]; ext_val <= r[17:6]; ext_drive <= r[29:18];
        repeat (8) @(posedge clk);
        @(negedge clk);
        x = exp_pad();
        // a running divided clock is checked on its own, not here
        // with the rc oscillator the clock runs even while debug is on,
        // since debug data then sits on pin 3.2
        m = (cfg[1] & cfg[3]) ? 12'h7ff : 12'hfff;
        pv = (x[11:0] & ext_drive & ext_val) | (x[11:0] & ~ext_drive)
           | (~x[11:0] & x[23:12]);
        check("pad enable", x[11:0] & m, {p3oe, p1oe} & m);
        lo = ~x[11:0] & m;
        check("pad value", x[23:12] & lo, {p3o, p1o} & lo);
        check("port input", pv & m, {p3i, p1i} & m);
        check("event input", {4'h0, pv[7:0]}, {4'h0, ev});
        // slave select follows pin 1.4 whenever spi is on, either role
        ai = {2'h0, cfg[0] ? pv[3] : 1'b1, cfg[2] & pv[3],
              !cfg[2] | (cfg[1] ? pv[10] : pv[11]), cfg[4] ? pv[4] : 1'b1,
              cfg[6] ? pv[8] : 1'b1, pv[5], pv[7], pv[6], 2'h1};
        mi = {2'h0, misc};
        check("reset dbg in", ai & 12'h380, mi & 12'h380);
        check("spi uart in", ai & 12'h07c, mi & 12'h07c);
        check("clock ratio", ai & 12'h003, mi & 12'h003);
        // the divided clock must flip at every edge, period of two
        if (fix && c == 8'h0a) begin
            repeat (6) begin
                pv[0] = p3o[3];
                @(negedge clk);
                check("clock out", {11'h0, ~pv[0]}, {11'h0, p3o[3]});
                check("clock out enable", 12'h0, {11'h0, p3oe[3]});
            end
        end
    endtask

    // ****************************************************************
    // main sequence and hang guard
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        logic [7:0] corner [8];
        corner = '{8'h07, 8'h30, 8'h10, 8'h0a, 8'h04, 8'h40, 8'h80, 8'h0e};
        repeat (10) @(posedge clk);
        @(negedge clk);
        check("reset enable", 12'hfff, {p3oe, p1oe});
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (corner[i]) step(corner[i], 1'b1);
        repeat (300) step(8'h00, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
